// ===== rtl/rfsq_pkg.sv
// Constants for the receive flow size-based first-buffer queue select.
// Assumes a word-wide register port and a 40 MHz system clock.
package rfsq_pkg;

   // Geometry
   localparam int NUM_FLOWS = 4;
   localparam int FLOW_W = 2;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int LEN_W = 22;
   localparam int THR_W = 16;
   localparam int QM_W = 2;
   localparam int QN_W = 12;
   localparam int EN_W = 3;
   localparam int BR_W = 2;
   localparam int THR_SHIFT = 5;

   // Register offsets within one flow, the flow stride and region, the base of the per-flow enable registers and the status address
   localparam logic [ADDR_W-1:0] FLOW_STRIDE = 12'h020;
   localparam logic [ADDR_W-1:0] FLOW_REGION = 12'h080;
   localparam logic [ADDR_W-1:0] OFS_SIZE0_QUEUE = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_LOW_THRESH = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_UPPER_SIZE1 = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_SIZE2_SIZE3 = 12'h01C;
   localparam logic [ADDR_W-1:0] OFS_THRESH_EN = 12'h100;
   localparam logic [ADDR_W-1:0] OFS_SELECT_STATUS = 12'h200;

   // Field positions (least significant bit of each field)
   localparam int HI_THR_LSB = 16;
   localparam int LO_THR_LSB = 0;
   localparam int HI_QM_LSB = 28;
   localparam int HI_QN_LSB = 16;
   localparam int LO_QM_LSB = 12;
   localparam int LO_QN_LSB = 0;
   localparam int STAT_BR_LSB = 16;
   localparam int EN_LOW_BIT = 0;
   localparam int EN_MID_BIT = 1;
   localparam int EN_UPPER_BIT = 2;

   // Reset values
   localparam logic [THR_W-1:0] THR_RST = 16'h0000;
   localparam logic [QM_W-1:0] QM_RST = 2'h0;
   localparam logic [QN_W-1:0] QN_RST = 12'h000;
   localparam logic [EN_W-1:0] EN_RST = 3'h0;
   localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

   // Size brackets
   typedef enum logic [BR_W-1:0] {
      RFSQ_BR0 = 2'h0,
      RFSQ_BR1 = 2'h1,
      RFSQ_BR2 = 2'h2,
      RFSQ_BR3 = 2'h3
   } rfsq_bracket_t;

endpackage

// ===== rtl/rfsq_select.sv
// Per-flow size thresholds, bracket queue registers and the start-of-packet
// free queue selection for the receive DMA port.
// Assumes a one-cycle register port master and a receive port that asks for
// one selection at a time; all inputs are synchronous to mclk.
//
// Operation
// - The upper threshold is shifted left five places before it is compared with the packet length.
// - A length above the middle threshold and at most the scaled upper threshold takes the size-2 queue pair.
// - Reserved bits of both flow registers read as zero and ignore writes.
// - Register G holds the size-1 queue manager index and queue number in its low half.
// - Register H holds the size-2 queue manager index and queue number in its high half.
// - A length that fits no enabled threshold takes the size-3 queue pair from the low half of H.
// - Registers G and H of flow N sit at 0x018 and 0x01C plus 32 times N.
// - Threshold and queue fields are write-only and reset to zero, reserved bits are read-only.
// - The threshold and bracket queue fields are an optional feature that may be left out.
// - A length at most the scaled lowest threshold takes the size-0 queue pair.
// - With thresholds disabled the first buffer always comes from the size-0 queue pair.
// - A length above the scaled lowest and at most the scaled middle threshold takes the size-1 pair.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

module rfsq_select
   import rfsq_pkg::*;
#(
   parameter bit SIZE_SEL_PRESENT = 1'b1
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic sel_req,
   input wire logic [FLOW_W-1:0] sel_flow,
   input wire logic [LEN_W-1:0] sel_pkt_len,
   output logic sel_valid,
   output logic [BR_W-1:0] sel_bracket,
   output logic [QM_W-1:0] sel_queue_manager,
   output logic [QN_W-1:0] sel_queue_number
);

   ////////////////////////////////////////////////////////////////////////////
   // Decode and arithmetic helpers

   // A flow register hit: inside the flow region and at the word offset
   function automatic logic fn_flow_hit(input logic [ADDR_W-1:0] addr,
                                        input logic [ADDR_W-1:0] ofs);
      fn_flow_hit = (addr < FLOW_REGION) && (addr[4:0] == ofs[4:0]);
   endfunction

   function automatic logic [FLOW_W-1:0] fn_flow_idx(
      input logic [ADDR_W-1:0] addr);
      fn_flow_idx = addr[FLOW_W+4:5];
   endfunction

   function automatic logic fn_en_hit(input logic [ADDR_W-1:0] addr);
      fn_en_hit = (addr[ADDR_W-1:4] == OFS_THRESH_EN[ADDR_W-1:4]) &&
                  (addr[1:0] == 2'h0);
   endfunction

   // Thresholds count 32-byte units
   function automatic logic [LEN_W-1:0] fn_scale(input logic [THR_W-1:0] t);
      fn_scale = LEN_W'(t) << THR_SHIFT;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage

   logic [THR_W-1:0] thr0_ff [NUM_FLOWS];
   logic [THR_W-1:0] thr1_ff [NUM_FLOWS];
   logic [THR_W-1:0] thr2_ff [NUM_FLOWS];
   logic [QM_W-1:0] qm0_ff [NUM_FLOWS];
   logic [QN_W-1:0] qn0_ff [NUM_FLOWS];
   logic [QM_W-1:0] qm1_ff [NUM_FLOWS];
   logic [QN_W-1:0] qn1_ff [NUM_FLOWS];
   logic [QM_W-1:0] qm2_ff [NUM_FLOWS];
   logic [QN_W-1:0] qn2_ff [NUM_FLOWS];
   logic [QM_W-1:0] qm3_ff [NUM_FLOWS];
   logic [QN_W-1:0] qn3_ff [NUM_FLOWS];
   logic [EN_W-1:0] en_ff [NUM_FLOWS];
   logic [DATA_W-1:0] rdata_ff;
   logic [DATA_W-1:0] nxt_rdata;
   logic sel_valid_ff;
   logic [BR_W-1:0] sel_bracket_ff;
   logic [QM_W-1:0] sel_qm_ff;
   logic [QN_W-1:0] sel_qn_ff;
   rfsq_bracket_t nxt_bracket;
   logic [QM_W-1:0] nxt_qm;
   logic [QN_W-1:0] nxt_qn;
   logic [FLOW_W-1:0] widx;
   logic wr_d;
   logic wr_f;
   logic wr_g;
   logic wr_h;
   logic wr_en;

   assign widx = fn_flow_idx(reg_addr);
   assign wr_d = reg_wr && fn_flow_hit(reg_addr, OFS_SIZE0_QUEUE);
   assign wr_f = reg_wr && fn_flow_hit(reg_addr, OFS_LOW_THRESH);
   // Without the optional feature, G and H swallow writes
   assign wr_g = reg_wr && SIZE_SEL_PRESENT &&
                 fn_flow_hit(reg_addr, OFS_UPPER_SIZE1);
   assign wr_h = reg_wr && SIZE_SEL_PRESENT &&
                 fn_flow_hit(reg_addr, OFS_SIZE2_SIZE3);
   assign wr_en = reg_wr && fn_en_hit(reg_addr);

   ////////////////////////////////////////////////////////////////////////////
   // Threshold registers

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_FLOWS; i++) begin
            thr0_ff[i] <= THR_RST;
            thr1_ff[i] <= THR_RST;
            thr2_ff[i] <= THR_RST;
         end
      end else begin
         if (wr_f) begin
            thr0_ff[widx] <= reg_wdata[HI_THR_LSB +: THR_W];
            thr1_ff[widx] <= reg_wdata[LO_THR_LSB +: THR_W];
         end
         if (wr_g) begin
            thr2_ff[widx] <= reg_wdata[HI_THR_LSB +: THR_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bracket queue registers; reserved bits are simply never stored

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_FLOWS; i++) begin
            qm0_ff[i] <= QM_RST;
            qn0_ff[i] <= QN_RST;
            qm1_ff[i] <= QM_RST;
            qn1_ff[i] <= QN_RST;
            qm2_ff[i] <= QM_RST;
            qn2_ff[i] <= QN_RST;
            qm3_ff[i] <= QM_RST;
            qn3_ff[i] <= QN_RST;
         end
      end else begin
         if (wr_d) begin
            qm0_ff[widx] <= reg_wdata[HI_QM_LSB +: QM_W];
            qn0_ff[widx] <= reg_wdata[HI_QN_LSB +: QN_W];
         end
         if (wr_g) begin
            qm1_ff[widx] <= reg_wdata[LO_QM_LSB +: QM_W];
            qn1_ff[widx] <= reg_wdata[LO_QN_LSB +: QN_W];
         end
         if (wr_h) begin
            qm2_ff[widx] <= reg_wdata[HI_QM_LSB +: QM_W];
            qn2_ff[widx] <= reg_wdata[HI_QN_LSB +: QN_W];
            qm3_ff[widx] <= reg_wdata[LO_QM_LSB +: QM_W];
            qn3_ff[widx] <= reg_wdata[LO_QN_LSB +: QN_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Threshold enables

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_FLOWS; i++) begin
            en_ff[i] <= EN_RST;
         end
      end else if (wr_en) begin
         en_ff[reg_addr[3:2]] <= reg_wdata[EN_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path: write-only fields and reserved bits return zero

   always_comb begin
      nxt_rdata = RDATA_RST;
      if (fn_en_hit(reg_addr)) begin
         nxt_rdata[EN_W-1:0] = en_ff[reg_addr[3:2]];
      end else if (reg_addr == OFS_SELECT_STATUS) begin
         nxt_rdata[STAT_BR_LSB +: BR_W] = sel_bracket_ff;
         nxt_rdata[LO_QM_LSB +: QM_W] = sel_qm_ff;
         nxt_rdata[LO_QN_LSB +: QN_W] = sel_qn_ff;
      end
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_ff <= RDATA_RST;
      end else if (reg_rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= RDATA_RST;
      end
   end

   assign reg_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Bracket choice
   // Thresholds are static while channels are off, so the compare is done
   // straight off the registers without a shadow copy.

   always_comb begin
      nxt_bracket = RFSQ_BR0;
      if (SIZE_SEL_PRESENT && (en_ff[sel_flow] != EN_RST)) begin
         if (en_ff[sel_flow][EN_LOW_BIT] &&
             (sel_pkt_len <= fn_scale(thr0_ff[sel_flow]))) begin
            nxt_bracket = RFSQ_BR0;
         end else if (en_ff[sel_flow][EN_MID_BIT] &&
                  (sel_pkt_len <= fn_scale(thr1_ff[sel_flow]))) begin
            nxt_bracket = RFSQ_BR1;
         end else if (en_ff[sel_flow][EN_UPPER_BIT] &&
                  (sel_pkt_len <= fn_scale(thr2_ff[sel_flow]))) begin
            nxt_bracket = RFSQ_BR2;
         end else begin
            nxt_bracket = RFSQ_BR3;
         end
      end
   end

   always_comb begin
      case (nxt_bracket)
         RFSQ_BR0: begin
            nxt_qm = qm0_ff[sel_flow];
            nxt_qn = qn0_ff[sel_flow];
         end
         RFSQ_BR1: begin
            nxt_qm = qm1_ff[sel_flow];
            nxt_qn = qn1_ff[sel_flow];
         end
         RFSQ_BR2: begin
            nxt_qm = qm2_ff[sel_flow];
            nxt_qn = qn2_ff[sel_flow];
         end
         RFSQ_BR3: begin
            nxt_qm = qm3_ff[sel_flow];
            nxt_qn = qn3_ff[sel_flow];
         end
         default: begin
            nxt_qm = QM_RST;
            nxt_qn = QN_RST;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Selection answer; the queue fields hold until the next request

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sel_valid_ff <= 1'b0;
      end else begin
         sel_valid_ff <= sel_req;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sel_bracket_ff <= RFSQ_BR0;
         sel_qm_ff <= QM_RST;
         sel_qn_ff <= QN_RST;
      end else if (sel_req) begin
         sel_bracket_ff <= nxt_bracket;
         sel_qm_ff <= nxt_qm;
         sel_qn_ff <= nxt_qn;
      end
   end

   assign sel_valid = sel_valid_ff;
   assign sel_bracket = sel_bracket_ff;
   assign sel_queue_manager = sel_qm_ff;
   assign sel_queue_number = sel_qn_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [LEN_W-1:0] chk_len_ff;
   logic [FLOW_W-1:0] chk_flow_ff;
   logic [FLOW_W-1:0] chk_widx_ff;
   logic [DATA_W-1:0] chk_wdata_ff;
   logic chk_rd_gh_ff;

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         chk_len_ff <= '0;
         chk_flow_ff <= '0;
         chk_widx_ff <= '0;
         chk_wdata_ff <= '0;
         chk_rd_gh_ff <= 1'b0;
      end else begin
         if (sel_req) begin
            chk_len_ff <= sel_pkt_len;
            chk_flow_ff <= sel_flow;
         end
         chk_widx_ff <= widx;
         chk_wdata_ff <= reg_wdata;
         chk_rd_gh_ff <= reg_rd &&
                         (fn_flow_hit(reg_addr, OFS_UPPER_SIZE1) ||
                          fn_flow_hit(reg_addr, OFS_SIZE2_SIZE3));
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_take;
      sel_req;
   endsequence

   sequence s_answer;
      sel_valid_ff && (sel_bracket_ff == $past(nxt_bracket));
   endsequence

   a_sel_one_answer: assert property (s_take |=> s_answer)
      else $error("selection answer missing or wrong bracket");

   a_sel_no_extra: assert property (!sel_req |=> !sel_valid_ff)
      else $error("selection answer without request");

   a_upper_scale: assert property (
      sel_valid_ff && (sel_bracket_ff == RFSQ_BR2) |->
         (chk_len_ff <= LEN_W'(32 * thr2_ff[chk_flow_ff])) &&
         (chk_len_ff > fn_scale(thr1_ff[chk_flow_ff]) ||
          !en_ff[chk_flow_ff][EN_MID_BIT]))
      else $error("size-2 bracket outside scaled upper threshold");

   a_size2_pair: assert property (
      sel_valid_ff && (sel_bracket_ff == RFSQ_BR2) |->
         (sel_qm_ff == qm2_ff[chk_flow_ff]) &&
         (sel_qn_ff == qn2_ff[chk_flow_ff]))
      else $error("size-2 bracket gave wrong queue pair");

   a_reserved_zero: assert property (
      chk_rd_gh_ff |-> (reg_rdata[31:30] == 2'h0) &&
                       (reg_rdata[15:14] == 2'h0))
      else $error("reserved bits read nonzero");

   a_write_only: assert property (chk_rd_gh_ff |-> reg_rdata == 32'h0)
      else $error("write-only fields read back");

   a_size1_pair: assert property (
      sel_valid_ff && (sel_bracket_ff == RFSQ_BR1) |->
         (sel_qm_ff == qm1_ff[chk_flow_ff]) &&
         (sel_qn_ff == qn1_ff[chk_flow_ff]))
      else $error("size-1 bracket gave wrong queue pair");

   a_size2_store: assert property (
      wr_h |=> (qm2_ff[chk_widx_ff] == chk_wdata_ff[29:28]) &&
               (qn2_ff[chk_widx_ff] == chk_wdata_ff[27:16]))
      else $error("size-2 queue fields not stored");

   a_size3_fallback: assert property (
      sel_valid_ff && (sel_bracket_ff == RFSQ_BR3) |->
         (sel_qm_ff == qm3_ff[chk_flow_ff]) &&
         (sel_qn_ff == qn3_ff[chk_flow_ff]) &&
         !(en_ff[chk_flow_ff][EN_UPPER_BIT] &&
           chk_len_ff <= fn_scale(thr2_ff[chk_flow_ff])))
      else $error("size-3 bracket chosen while a threshold fits");

   a_flow_offset: assert property (
      wr_g |=> thr2_ff[chk_widx_ff] == chk_wdata_ff[31:16])
      else $error("upper threshold not stored at flow offset");

   a_lowest_fit: assert property (
      sel_req && SIZE_SEL_PRESENT && en_ff[sel_flow][EN_LOW_BIT] &&
      (sel_pkt_len <= fn_scale(thr0_ff[sel_flow])) |=>
         (sel_bracket_ff == RFSQ_BR0) && (sel_qm_ff == qm0_ff[chk_flow_ff]))
      else $error("length under lowest threshold missed size-0");

   a_disabled_zero: assert property (
      sel_req && (en_ff[sel_flow] == EN_RST) |=>
         (sel_bracket_ff == RFSQ_BR0) && (sel_qn_ff == qn0_ff[chk_flow_ff]))
      else $error("disabled thresholds did not pick size-0");

   a_middle_fit: assert property (
      sel_valid_ff && (sel_bracket_ff == RFSQ_BR1) |->
         (chk_len_ff <= fn_scale(thr1_ff[chk_flow_ff])) &&
         (chk_len_ff > fn_scale(thr0_ff[chk_flow_ff]) ||
          !en_ff[chk_flow_ff][EN_LOW_BIT]))
      else $error("size-1 bracket outside middle threshold");

endmodule

// ===== verif/rfsq_rx_port.sv
// Receive port model: issues one selection request per packet.
// Assumes the bench calls request() and checks the answer itself.
`timescale 1ns/1ps

module rfsq_rx_port
   import rfsq_pkg::*;
(
   input wire logic mclk,
   output logic sel_req,
   output logic [FLOW_W-1:0] sel_flow,
   output logic [LEN_W-1:0] sel_pkt_len
);
   initial begin
      sel_req = 1'b0;
      sel_flow = '0;
      sel_pkt_len = '0;
   end

   // Flow and length only qualify the request cycle; afterwards they
   // show the inverse so a design that samples late sees garbage
   task automatic request(input logic [FLOW_W-1:0] f,
                          input logic [LEN_W-1:0] l);
      @(posedge mclk);
      sel_req <= 1'b1;
      sel_flow <= f;
      sel_pkt_len <= l;
      @(posedge mclk);
      sel_req <= 1'b0;
      sel_flow <= ~f;
      sel_pkt_len <= ~l;
   endtask
endmodule

// ===== verif/rfsq_select_bench.sv
// Self-checking bench for the size-based first-buffer queue select.
// Assumes the one-cycle register port and one answer a cycle after a request.
`timescale 1ns/1ps

module rfsq_select_bench;
   import rfsq_pkg::*;

   logic mclk;
   logic sys_rst;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic sel_req;
   logic [FLOW_W-1:0] sel_flow;
   logic [LEN_W-1:0] sel_pkt_len;
   logic sel_valid;
   logic [BR_W-1:0] sel_bracket;
   logic [QM_W-1:0] sel_queue_manager;
   logic [QN_W-1:0] sel_queue_number;
   logic [BR_W-1:0] lite_bracket;
   logic [QM_W-1:0] lite_qm;
   logic [QN_W-1:0] lite_qn;
   int fails;
   int n_checks;

   rfsq_select DUT (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sel_req(sel_req), .sel_flow(sel_flow),
      .sel_pkt_len(sel_pkt_len), .sel_valid(sel_valid),
      .sel_bracket(sel_bracket), .sel_queue_manager(sel_queue_manager),
      .sel_queue_number(sel_queue_number)
   );

   // Same bus and requests, optional size selection left out
   rfsq_select #(.SIZE_SEL_PRESENT(1'b0)) dut_lite (
      .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(), .sel_req(sel_req), .sel_flow(sel_flow),
      .sel_pkt_len(sel_pkt_len), .sel_valid(),
      .sel_bracket(lite_bracket), .sel_queue_manager(lite_qm),
      .sel_queue_number(lite_qn)
   );

   rfsq_rx_port u_port (
      .mclk(mclk), .sel_req(sel_req), .sel_flow(sel_flow),
      .sel_pkt_len(sel_pkt_len)
   );

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask

   // Read data stand only in the cycle after the strobe, then drop to 0
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
      @(posedge mclk);
      #1;
      chk(reg_rdata, 32'h0000_0000);
   endtask

   task automatic sel(input logic [FLOW_W-1:0] f, input logic [LEN_W-1:0] l,
                      input logic [1:0] br, input logic [1:0] qm,
                      input logic [11:0] qn);
      u_port.request(f, l);
      #1;
      chk(sel_valid, 32'h1);
      chk(sel_bracket, br);
      chk(sel_queue_manager, qm);
      chk(sel_queue_number, qn);
      @(posedge mclk);
      #1;
      chk(sel_valid, 32'h0);
      chk(sel_queue_number, qn);
   endtask

   initial begin
      repeat (6000) @(posedge mclk);
      fails++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      fails = 0;
      n_checks = 0;
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;

      // Reset state: write-only fields read 0, selection is bracket 0
      rd(12'h018, 32'h0000_0000);
      rd(12'h01C, 32'h0000_0000);
      rd(12'h0F0, 32'h0000_0000);
      sel(2'h1, 22'h3FFFFF, 2'h0, 2'h0, 12'h000);
      $display("test reset done");

      // Flow 1 programmed while idle; upper above middle, reserved bits set
      wr(12'h02C, 32'h1111_0000);
      wr(12'h034, 32'h0002_0004);
      wr(12'h038, 32'h0008_E222);
      wr(12'h03C, 32'hF333_C444);
      rd(12'h038, 32'h0000_0000);
      rd(12'h03C, 32'h0000_0000);
      sel(2'h1, 22'h000500, 2'h0, 2'h1, 12'h111);
      wr(12'h104, 32'h0000_0007);
      rd(12'h104, 32'h0000_0007);
      $display("test program done");

      // Boundaries of every bracket; 256 vs 257 shows the five-place shift
      sel(2'h1, 22'h000040, 2'h0, 2'h1, 12'h111);
      sel(2'h1, 22'h000041, 2'h1, 2'h2, 12'h222);
      sel(2'h1, 22'h000080, 2'h1, 2'h2, 12'h222);
      sel(2'h1, 22'h000081, 2'h2, 2'h3, 12'h333);
      sel(2'h1, 22'h000100, 2'h2, 2'h3, 12'h333);
      sel(2'h1, 22'h000101, 2'h3, 2'h0, 12'h444);
      chk(lite_bracket, 32'h0);
      chk(lite_qm, 32'h1);
      chk(lite_qn, 32'h111);
      rd(12'h200, 32'h0003_0444);
      $display("test brackets done");

      // Only the upper threshold enabled: lower ones are skipped
      wr(12'h104, 32'h0000_0004);
      sel(2'h1, 22'h000001, 2'h2, 2'h3, 12'h333);
      sel(2'h1, 22'h000101, 2'h3, 2'h0, 12'h444);
      $display("test order done");

      // Flow 3 at its own offsets, flow 1 untouched
      wr(12'h078, 32'h0001_0000);
      wr(12'h07C, 32'h2555_0000);
      wr(12'h10C, 32'h0000_0004);
      sel(2'h3, 22'h000020, 2'h2, 2'h2, 12'h555);
      sel(2'h3, 22'h000021, 2'h3, 2'h0, 12'h000);
      sel(2'h1, 22'h000020, 2'h2, 2'h3, 12'h333);
      sel(2'h0, 22'h000020, 2'h0, 2'h0, 12'h000);
      $display("test flows done");

      // Second reset in mid-run clears every field
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      sel(2'h1, 22'h000101, 2'h0, 2'h0, 12'h000);
      wr(12'h104, 32'h0000_0004);
      sel(2'h1, 22'h000001, 2'h3, 2'h0, 12'h000);
      $display("test rereset done");
      close_out();
   end
endmodule
